/* src/sfb_map.vh */
/*
 * Holds the opcodes, status bit positions, sizes and timing counts of the
 * serial flash boot sequencer. Assumes a 250 MHz system clock.
 */
`ifndef SFB_MAP_VH
`define SFB_MAP_VH
`define SFB_OP_FAST_READ    8'h0B
`define SFB_OP_READ_STATUS  8'h05
`define SFB_OP_WRITE_STATUS 8'h01
`define SFB_OP_WRITE_ENABLE 8'h06
`define SFB_OP_PAGE_PROGRAM 8'h02
`define SFB_OP_SECTOR_ERASE 8'h20
`define SFB_OP_CHIP_ERASE   8'h C7
`define SFB_BIT_BUSY        0
`define SFB_BIT_WRITE_LATCH 1
`define SFB_STATUS_CLEAR    8'h00
`define SFB_ADDR_W          24
`define SFB_PAGE_BYTES      256
`define SFB_SECTOR_BYTES    4096
`define SFB_CLK_KHZ         250000
`define SFB_SLOW_KHZ        1420
`define SFB_FAST_KHZ        30000
`define SFB_SLOW_HALF       ((`SFB_CLK_KHZ + 2 * `SFB_SLOW_KHZ - 1) / (2 * `SFB_SLOW_KHZ))
`define SFB_FAST_HALF       ((`SFB_CLK_KHZ + 2 * `SFB_FAST_KHZ - 1) / (2 * `SFB_FAST_KHZ))
`define SFB_DESELECT_NS     200
`define SFB_DESELECT_CYC    ((`SFB_DESELECT_NS + 3) / 4)
`endif

/* src/sfb_sync.v */
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a plain level with no timing relation to sys_clk.
 */
module sfb_sync (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst,
    // Level
    input  wire din,
    output reg  dout
);
    reg meta;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // sfb_sync

/* src/sfb_seq.v */
/*
 * Serial flash boot sequencer: single-width SPI mode 0 master that copies
 * the firmware image into program memory at boot and then serves page
 * program and erase requests. Assumes hold and write-protect pins of the
 * flash are pulled high on the board and the flash is on select zero.
 */
`include "sfb_map.vh"
module sfb_seq (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Device reset pin and boot setup
    input  wire        device_reset_n,
    input  wire [23:0] image_bytes,
    // Program memory write port
    output reg         pmem_we,
    output reg  [23:0] pmem_addr,
    output reg  [7:0]  pmem_data,
    output reg         boot_done,
    // Program and erase requests: kind 0 page, 1 sector, 2 chip
    input  wire        op_start,
    input  wire [1:0]  op_kind,
    input  wire [23:0] op_addr,
    input  wire [7:0]  op_wdata,
    output reg         op_wdata_take,
    output reg         op_busy,
    // Second select, driven by the user
    input  wire        select_one_req,
    // Flash pins
    output reg         flash_serial_clock,
    output reg         flash_serial_clock_oe,
    output reg         flash_serial_out,
    output reg         flash_serial_out_oe,
    output reg         flash_select_zero_n,
    output reg         flash_select_zero_oe,
    output reg         flash_select_one_n,
    input  wire        flash_serial_in
);
    localparam S_RESET = 4'h0, S_WRITE_ENABLE_CMD = 4'h1, S_POLLW = 4'h2, S_WRITE_STATUS_CMD = 4'h3;
    localparam S_POLLB = 4'h4, S_READ = 4'h5, S_IDLE = 4'h6, S_OP = 4'h7;
    localparam S_GAP = 4'h8, S_SHIFT = 4'h9;

    wire rstn_s;
    wire miso_s;
    sfb_sync u_rst_sync (.sys_clk(sys_clk), .rst(rst), .din(device_reset_n), .dout(rstn_s));
    sfb_sync u_in_sync (.sys_clk(sys_clk), .rst(rst), .din(flash_serial_in), .dout(miso_s));

    reg [3:0]  state;
    reg [3:0]  ret_state;
    reg        fast;
    reg [7:0]  div;
    reg        phase;
    reg [7:0]  txb;
    reg [7:0]  rxb;
    reg [2:0]  bitc;
    reg [2:0]  byte_i;
    reg [23:0] count;
    reg [23:0] cur_addr;
    reg [1:0]  kind;
    reg        pending;
    reg [7:0]  gapc;
    reg        boot_phase;

    // A half-period tick; the rate is slow until the boot fast read, then fast, whatever part is attached.
    localparam integer SLOW_HALF_I = `SFB_SLOW_HALF;
    localparam integer FAST_HALF_I = `SFB_FAST_HALF;
    localparam integer GAP_CYC_I   = `SFB_DESELECT_CYC;
    localparam [7:0]   SLOW_HALF   = SLOW_HALF_I[7:0];
    localparam [7:0]   FAST_HALF   = FAST_HALF_I[7:0];
    localparam [7:0]   GAP_CYC     = GAP_CYC_I[7:0];
    wire [7:0] half = fast ? FAST_HALF : SLOW_HALF;
    wire       tick = (div == half - 8'd1);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= S_RESET; ret_state <= S_RESET; fast <= 1'b0; div <= 8'h00;
            phase <= 1'b0; txb <= 8'h00; rxb <= 8'h00; bitc <= 3'h0; byte_i <= 3'h0;
            count <= 24'h000000; cur_addr <= 24'h000000; kind <= 2'h0; pending <= 1'b0;
            gapc <= 8'h00; boot_phase <= 1'b1;
            pmem_we <= 1'b0; pmem_addr <= 24'h000000; pmem_data <= 8'h00;
            boot_done <= 1'b0; op_wdata_take <= 1'b0; op_busy <= 1'b0;
            flash_serial_clock <= 1'b0; flash_serial_clock_oe <= 1'b0;
            flash_serial_out <= 1'b0; flash_serial_out_oe <= 1'b0;
            flash_select_zero_n <= 1'b1; flash_select_zero_oe <= 1'b0;
            flash_select_one_n <= 1'b1;
        end else begin
            pmem_we <= 1'b0;
            op_wdata_take <= 1'b0;
            flash_select_one_n <= ~select_one_req;
            div <= tick ? 8'h00 : div + 8'd1;
            if (!rstn_s) begin
                // Release the pins so an outside programmer can own the flash.
                flash_serial_clock_oe <= 1'b0;
                flash_serial_out_oe <= 1'b0;
                flash_select_zero_oe <= 1'b0;
                flash_select_zero_n <= 1'b1;
                flash_serial_clock <= 1'b0;
                state <= S_RESET; fast <= 1'b0; boot_phase <= 1'b1;
                boot_done <= 1'b0; op_busy <= 1'b0; pending <= 1'b0;
            end else begin
                flash_serial_clock_oe <= 1'b1;
                flash_serial_out_oe <= 1'b1;
                flash_select_zero_oe <= 1'b1;
                if (op_start && !op_busy && boot_done) begin
                    pending <= 1'b1; op_busy <= 1'b1; kind <= op_kind;
                    cur_addr <= op_addr;
                end
                case (state)
                S_RESET: begin
                    // Protection is assumed on and is always cleared at boot.
                    // The latch poll step issues the write enable itself.
                    byte_i <= 3'h0;
                    ret_state <= S_POLLW; state <= S_POLLW;
                end
                S_GAP: begin
                    flash_select_zero_n <= 1'b1;
                    gapc <= gapc + 8'd1;
                    if (gapc >= GAP_CYC && tick) begin
                        // Every command goes to select zero.
                        flash_select_zero_n <= 1'b0;
                        bitc <= 3'h7; phase <= 1'b0;
                        flash_serial_out <= txb[7];
                        state <= S_SHIFT;
                    end
                end
                S_SHIFT: if (tick) begin
                    phase <= ~phase;
                    flash_serial_clock <= ~phase;
                    if (!phase) begin
                        rxb <= {rxb[6:0], miso_s};
                    end else if (bitc != 3'h0) begin
                        bitc <= bitc - 3'h1;
                        txb <= {txb[6:0], 1'b0};
                        flash_serial_out <= txb[6];
                    end else begin
                        state <= ret_state;
                    end
                end
                S_POLLW: begin
                    // Each status read is its own frame of opcode plus one byte.
                    if (byte_i == 3'h0) begin
                        txb <= `SFB_OP_WRITE_ENABLE;
                        byte_i <= 3'h1; state <= S_GAP; gapc <= 8'h00;
                    end else if (byte_i == 3'h1) begin
                        txb <= `SFB_OP_READ_STATUS; byte_i <= byte_i + 3'h1;
                        state <= S_GAP; gapc <= 8'h00;
                    end else if (byte_i == 3'h2) begin
                        txb <= 8'h00; byte_i <= 3'h3;
                        state <= S_SHIFT; bitc <= 3'h7; phase <= 1'b0;
                        flash_serial_out <= 1'b0;
                    end else if (rxb[`SFB_BIT_WRITE_LATCH]) begin
                        byte_i <= 3'h0; state <= boot_phase ? S_WRITE_STATUS_CMD : S_OP;
                    end else begin
                        byte_i <= 3'h1;
                    end
                end
                S_WRITE_STATUS_CMD: begin
                    if (byte_i == 3'h0) begin
                        txb <= `SFB_OP_WRITE_STATUS; byte_i <= 3'h1;
                        state <= S_GAP; gapc <= 8'h00; ret_state <= S_WRITE_STATUS_CMD;
                    end else if (byte_i == 3'h1) begin
                        // Exactly one zero status byte clears every protection bit.
                        txb <= `SFB_STATUS_CLEAR; byte_i <= 3'h2;
                        state <= S_SHIFT; bitc <= 3'h7; phase <= 1'b0;
                        flash_serial_out <= 1'b0;
                    end else begin
                        byte_i <= 3'h0; ret_state <= S_READ; state <= S_POLLB;
                    end
                end
                S_POLLB: begin
                    if (byte_i == 3'h0) begin
                        txb <= `SFB_OP_READ_STATUS; byte_i <= 3'h1;
                        state <= S_GAP; gapc <= 8'h00; ret_state <= S_POLLB;
                    end else if (byte_i == 3'h1) begin
                        txb <= 8'h00; byte_i <= 3'h2; state <= S_SHIFT;
                        bitc <= 3'h7; phase <= 1'b0; flash_serial_out <= 1'b0;
                    end else if (!rxb[`SFB_BIT_BUSY]) begin
                        byte_i <= 3'h0; flash_select_zero_n <= 1'b1;
                        state <= boot_phase ? S_READ : S_IDLE;
                        op_busy <= boot_phase ? op_busy : 1'b0;
                    end else begin
                        byte_i <= 3'h0;
                    end
                end
                S_READ: begin
                    // One fast read with an incrementing address fetches the image.
                    if (byte_i == 3'h0) begin
                        fast <= 1'b1;
                        txb <= `SFB_OP_FAST_READ; byte_i <= 3'h1;
                        state <= S_GAP; gapc <= 8'h00; ret_state <= S_READ;
                        count <= 24'h000000;
                    end else if (byte_i < 3'h5) begin
                        txb <= 8'h00; byte_i <= byte_i + 3'h1; state <= S_SHIFT;
                        bitc <= 3'h7; phase <= 1'b0; flash_serial_out <= 1'b0;
                    end else if (byte_i == 3'h7) begin
                        // Hand over one cycle after the last byte is stored.
                        flash_select_zero_n <= 1'b1;
                        boot_done <= 1'b1; boot_phase <= 1'b0; state <= S_IDLE;
                    end else begin
                        if (byte_i == 3'h6) begin
                            pmem_we <= 1'b1; pmem_addr <= count; pmem_data <= rxb;
                            count <= count + 24'd1;
                        end
                        byte_i <= 3'h6;
                        if (byte_i == 3'h6 && count + 24'd1 >= image_bytes) begin
                            byte_i <= 3'h7;
                        end else begin
                            txb <= 8'h00; state <= S_SHIFT; bitc <= 3'h7;
                            phase <= 1'b0; flash_serial_out <= 1'b0;
                        end
                    end
                end
                S_IDLE: begin
                    flash_select_zero_n <= 1'b1;
                    if (pending) begin
                        pending <= 1'b0; byte_i <= 3'h0; state <= S_POLLW; ret_state <= S_POLLW;
                    end
                end
                S_OP: begin
                    // The latch is seen set; now the program or erase itself.
                    ret_state <= S_OP;
                    if (byte_i == 3'h0) begin
                        txb <= (kind == 2'd0) ? `SFB_OP_PAGE_PROGRAM :
                               (kind == 2'd1) ? `SFB_OP_SECTOR_ERASE : `SFB_OP_CHIP_ERASE;
                        byte_i <= (kind == 2'd2) ? 3'h4 : 3'h1;
                        count <= 24'h000000;
                        state <= S_GAP; gapc <= 8'h00;
                    end else if (byte_i < 3'h4) begin
                        txb <= (byte_i == 3'h1) ? cur_addr[23:16] :
                               (byte_i == 3'h2) ? cur_addr[15:8] : cur_addr[7:0];
                        byte_i <= byte_i + 3'h1; state <= S_SHIFT; bitc <= 3'h7; phase <= 1'b0;
                        flash_serial_out <= (byte_i == 3'h1) ? cur_addr[23] :
                                            (byte_i == 3'h2) ? cur_addr[15] : cur_addr[7];
                    end else if (kind == 2'd0 && count != 24'd`SFB_PAGE_BYTES) begin
                        if (byte_i == 3'h4) count <= 24'h000000;
                        byte_i <= 3'h5;
                        if (byte_i == 3'h5) count <= count + 24'd1;
                        if (byte_i == 3'h4 || count + 24'd1 < 24'd`SFB_PAGE_BYTES) begin
                            // One full 256-byte page per program command.
                            txb <= op_wdata; op_wdata_take <= 1'b1;
                            state <= S_SHIFT; bitc <= 3'h7; phase <= 1'b0;
                            flash_serial_out <= op_wdata[7];
                        end else begin
                            count <= 24'd`SFB_PAGE_BYTES;
                        end
                    end else begin
                        // The flash drops its latch itself; the next request re-enables.
                        flash_select_zero_n <= 1'b1;
                        count <= 24'h000000; byte_i <= 3'h0; state <= S_POLLB;
                    end
                end
                default: state <= S_RESET;
                endcase
            end
        end
    end
    // Hold and write-protect pins have no port here at all.
endmodule // sfb_seq

/* dv/sfb_seq_properties.sv */
/* Port assertions for the serial flash boot sequencer.
   Assumes it is bound to sfb_seq, with rst as an asynchronous reset. */
module sfb_seq_properties (
    // Clock and reset
    input logic sys_clk,
    input logic rst,
    // Controls and status
    input logic device_reset_n,
    input logic select_one_req,
    input logic op_start,
    input logic op_busy,
    input logic op_wdata_take,
    input logic boot_done,
    input logic pmem_we,
    // Flash pins
    input logic flash_serial_clock,
    input logic flash_serial_clock_oe,
    input logic flash_serial_out,
    input logic flash_serial_out_oe,
    input logic flash_select_zero_n,
    input logic flash_select_zero_oe,
    input logic flash_select_one_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_sel_idle;
        $fell(flash_select_zero_n) |-> !flash_serial_clock;
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("clock high at select");
    property p_out_low;
        !flash_select_zero_n && !$stable(flash_serial_out) |-> !flash_serial_clock;
    endproperty
    a_out_low: assert property (p_out_low) else $error("data moved with clock high");
    property p_tri;
        !device_reset_n [*3] |=> !(flash_serial_clock_oe | flash_serial_out_oe
            | flash_select_zero_oe);
    endproperty
    a_tri: assert property (p_tri) else $error("pins driven in device reset");
    property p_sel1;
        1 |=> flash_select_one_n != $past(select_one_req);
    endproperty
    a_sel1: assert property (p_sel1) else $error("select one wrong");
    property p_accept;
        op_start && boot_done && !op_busy |=> op_busy;
    endproperty
    a_accept: assert property (p_accept) else $error("request not taken");
    property p_prebusy;
        !boot_done |-> !op_busy && !op_wdata_take;
    endproperty
    a_prebusy: assert property (p_prebusy) else $error("operation before boot end");
    property p_pmem;
        pmem_we |-> !boot_done;
    endproperty
    a_pmem: assert property (p_pmem) else $error("copy after hand over");
    property p_fast;
        boot_done && $rose(flash_serial_clock) |-> flash_serial_clock [*5] ##1
            !flash_serial_clock;
    endproperty
    a_fast: assert property (p_fast) else $error("fast half period wrong");
endmodule // sfb_seq_properties
bind sfb_seq sfb_seq_properties chk (.*);

/* dv/sfb_flash_model.sv */
/* Behavioural single-width serial flash, mode 0, with an error count.
   Assumes pins already resolved to wire levels; busy lasts BUSY_NS. */
module sfb_flash_model (
    // Serial pins
    input  wire  sck,
    input  wire  cs_n,
    input  wire  si,
    output logic so
);
    timeunit 1ns;
    timeprecision 100ps;
    parameter int BUSY_NS = 3000;
    logic [7:0]  mem [int];
    logic [7:0]  status = 8'h9C;
    logic [7:0]  op, sh, ob;
    logic [23:0] addr;
    logic [7:0]  ops [$];
    int          nbits, err, pa;
    initial so = 1'b0;
    function automatic logic [7:0] rd(int a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    always @(negedge cs_n) begin
        nbits = 0;
        if (sck === 1'b1) err++;
    end
    always @(posedge sck) if (!cs_n) begin
        sh = {sh[6:0], si};
        nbits++;
        if (nbits == 8) op = sh;
        if (nbits % 8 == 0 && nbits > 8 && nbits <= 32) addr = {addr[15:0], sh};
        if (nbits % 8 == 0 && nbits >= 40 && op == 8'h02 && status[1]) begin
            pa = {addr[23:8], addr[7:0] + 8'((nbits - 40) / 8)};
            mem[pa] = rd(pa) & sh;
        end
    end
    // Read data auto-increments; status repeats for as long as the clock runs.
    always @(negedge sck) if (!cs_n) begin
        if (nbits % 8 == 0) ob = (op == 8'h05) ? status : rd(addr + (nbits - 40) / 8);
        so = ob[7 - nbits % 8];
    end
    always @(posedge cs_n) if (nbits != 0) begin
        so = ~so;
        ops.push_back(op);
        if (nbits % 8 != 0 || sck === 1'b1) err++;
        if (status[0] && op != 8'h05) err++;
        if ((op == 8'h05 || op == 8'h01) && nbits != 16) err++;
        if (op == 8'h06) status[1] = 1'b1;
        else if (op inside {8'h01, 8'h02, 8'h20, 8'hC7}) begin
            if (!status[1]) err++;
            if (op == 8'h01) status[7:2] = sh[7:2];
            if (op == 8'h20) for (int i = 0; i < 4096; i++) mem.delete({addr[23:12], i[11:0]});
            if (op == 8'hC7) mem.delete();
            status[1:0] = 2'b01;
        end
    end
    always @(posedge status[0]) status[0] = #(BUSY_NS) 1'b0;
endmodule // sfb_flash_model

/* dv/sfb_tb.sv */
/* Self-checking bench for sfb_seq with a behavioural flash on select zero.
   Assumes select zero is pulled up and the serial clock pulled down on board. */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, rst, device_reset_n, op_start, select_one_req;
    logic [1:0]  op_kind;
    logic [23:0] image_bytes, op_addr, a;
    logic [7:0]  op_wdata;
    wire         pmem_we, boot_done, op_wdata_take, op_busy, flash_serial_in;
    wire         flash_serial_clock, flash_serial_clock_oe, flash_serial_out, flash_serial_out_oe;
    wire         flash_select_zero_n, flash_select_zero_oe, flash_select_one_n;
    wire [23:0]  pmem_addr;
    wire [7:0]   pmem_data;
    int          n_fail, checks_done, n_pm;
    logic [7:0]  img [$], page [$];
    sfb_seq dut (.*);
    sfb_flash_model fl (.sck(flash_serial_clock_oe ? flash_serial_clock : 1'b0),
        .cs_n(flash_select_zero_oe ? flash_select_zero_n : 1'b1),
        .si(flash_serial_out_oe ? flash_serial_out : 1'b0), .so(flash_serial_in));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #350000;
        n_fail++;
        results;
    end
    always @(negedge sys_clk) select_one_req <= 1'($urandom);
    always @(negedge sys_clk) if (pmem_we === 1'b1) begin
        chk("pmem_addr", pmem_addr, n_pm);
        chk("pmem_data", pmem_data, img[n_pm]);
        n_pm++;
    end
    // Status polls repeat a variable number of times, so runs of them count once.
    task automatic seq(input [39:0] e, input int n);
        logic [7:0] q [$];
        foreach (fl.ops[i]) if (!(q.size() > 0 && q[$] == 8'h05 && fl.ops[i] == 8'h05))
            q.push_back(fl.ops[i]);
        chk("frames", q.size(), n);
        for (int i = 0; i < n; i++) chk("opcode", q[i], e[8 * (n - 1 - i) +: 8]);
        fl.ops.delete();
    endtask
    task boot_chk;
        for (int t = 0; t < 40000 && boot_done !== 1'b1; t++) @(negedge sys_clk);
        chk("boot_done", boot_done, 1);
        chk("image_count", n_pm, 6);
        chk("status", fl.status, 0);
        seq(40'h0605010500 | 40'h0B, 5);
        $display("boot test finished");
    endtask
    task run_op(input [1:0] k, input [23:0] ad);
        int i;
        i = 0;
        op_wdata = page[0];
        @(negedge sys_clk);
        {op_kind, op_addr, op_start} = {k, ad, 1'b1};
        @(negedge sys_clk);
        op_start = 1'b0;
        chk("op_accept", op_busy, 1);
        for (int t = 0; t < 30000 && op_busy !== 1'b0; t++) begin
            @(negedge sys_clk);
            if (op_wdata_take === 1'b1 && i < 255) op_wdata = page[++i];
            op_start = (t == 40);
        end
        chk("op_done", op_busy, 0);
        $display("operation %0d test finished", k);
    endtask
    initial begin
        {device_reset_n, op_start, op_kind, op_addr, op_wdata} = '0;
        rst = 1'b1;
        image_bytes = 24'h000006;
        void'($urandom(91030));
        repeat (6) img.push_back(8'($urandom));
        repeat (256) page.push_back(8'($urandom));
        foreach (img[i]) fl.mem[i] = img[i];
        repeat (20) @(negedge sys_clk);
        {rst, device_reset_n} = 2'b01;
        repeat (100) @(negedge sys_clk);
        op_start = 1'b1;
        @(negedge sys_clk);
        op_start = 1'b0;
        boot_chk;
        a = $urandom & 24'hFFFF00;
        run_op(2, a);
        seq(40'h0605C705, 4);
        run_op(0, a);
        seq(40'h06050205, 4);
        for (int b = 0; b < 256; b++) chk("programmed", fl.rd(a + b), page[b]);
        run_op(1, {a[23:12], 12'($urandom)});
        seq(40'h06052005, 4);
        for (int b = 0; b < 256; b++) chk("erased", fl.rd(a + b), 8'hFF);
        device_reset_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("pin_enables", {flash_serial_clock_oe, flash_serial_out_oe, flash_select_zero_oe}, 0);
        foreach (img[i]) fl.mem[i] = img[i];
        n_pm = 0;
        device_reset_n = 1'b1;
        boot_chk;
        chk("flash_errors", fl.err, 0);
        results;
    end
endmodule // testbench
